// ---- rtl/standby_pkg.sv ----
// constants, types and carriers for the deep idle standby controller
package standby_pkg;

  localparam int CSI_N = 5;
  localparam int UART_N = 6;
  localparam int SEL_W = 3;
  localparam int CNT_W = 18;
  // default exponent of the shortest setup wait, 2**10 cycles
  localparam int STAB_BASE_DEFAULT = 10;
  localparam logic [SEL_W-1:0] SEL_RESET = 3'h0;
  localparam logic [CNT_W-1:0] CNT_ZERO = 18'h00000;
  localparam logic [CNT_W-1:0] CNT_ONE = 18'h00001;

  typedef enum logic [1:0] {
    S_RUN,
    S_IDLE,
    S_SETUP
  } standby_state_t;

  // clock source choices made by the peripherals' own registers
  typedef struct packed {
    logic subclock_used;
    logic timer_m_intosc8;
    logic timer_m_sub;
    logic wdt_intosc8;
    logic wdt_sub;
    logic watch_brg;
    logic [CSI_N-1:0] csi_ext_clock;
    logic uart0_ext_baud;
  } clock_select_t;

  // run enables and hold requests to the clock tree and peripherals
  typedef struct packed {
    logic main_osc_run;
    logic pll_run;
    logic cpu_run;
    logic dma_run;
    logic timer_p_run;
    logic timer_q_run;
    logic i2c_run;
    logic ext_uart_run;
    logic crc_run;
    logic irq_service_run;
    logic irq_detect_run;
    logic timer_m_run;
    logic wdt_run;
    logic watch_run;
    logic [CSI_N-1:0] csi_run;
    logic [UART_N-1:0] uart_run;
    logic adc_hold;
    logic dac_hold;
    logic rto_hold;
    logic key_run;
    logic port_hold;
    logic cpu_regs_hold;
    logic ram_retain;
  } gate_t;

endpackage

// ---- rtl/deep_idle_state.sv ----
// deep idle standby controller: clock gating, holds and setup wait on release
`timescale 1ns/100ps
module deep_idle_state
  import standby_pkg::*;
#(
  parameter int STAB_BASE = STAB_BASE_DEFAULT
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // power-save request from the CPU
  input wire logic idle_req,
  input wire logic irq_pending,
  // release sources and setup wait choice
  input wire logic release_evt,
  input wire logic [SEL_W-1:0] osc_stabilise_select,
  // clock source selections
  input wire clock_select_t cfg,
  // gating to the clock tree and peripherals
  output gate_t gates,
  // status
  output logic in_idle,
  output logic in_setup,
  output logic resume
);

  standby_state_t state, next_state;
  logic [CNT_W-1:0] count, next_count;
  logic [SEL_W-1:0] stab_sel, next_stab_sel;
  logic [CNT_W-1:0] target;
  gate_t next_gates;
  logic next_in_idle, next_in_setup, next_resume;

  // wait length is 2**(base+select) cycles; base is a parameter so sims can shorten it
  assign target = CNT_W'((32'h1 << (STAB_BASE + int'(stab_sel))) - 32'h1);

  // run enables for a given state; everything runs in normal operation
  function automatic gate_t gates_for(input standby_state_t st, input clock_select_t c);
    gate_t g;
    logic stopped;
    g = '0;
    stopped = (st != S_RUN);
    g.main_osc_run = 1'h1;
    g.pll_run = (st != S_IDLE);
    g.cpu_run = !stopped;
    g.dma_run = !stopped;
    g.timer_p_run = !stopped;
    g.timer_q_run = !stopped;
    g.i2c_run = !stopped;
    g.ext_uart_run = !stopped;
    g.crc_run = !stopped;
    g.irq_service_run = !stopped;
    g.irq_detect_run = 1'h1;
    g.timer_m_run = !stopped || c.timer_m_intosc8 || (c.subclock_used && c.timer_m_sub);
    g.wdt_run = !stopped || c.wdt_intosc8 || (c.subclock_used && c.wdt_sub);
    g.watch_run = !stopped || c.watch_brg || c.subclock_used;
    for (int i = 0; i < CSI_N; i++) begin
      g.csi_run[i] = !stopped || c.csi_ext_clock[i];
    end
    // only channel 0 on external baud
    g.uart_run = stopped ? {{(UART_N-1){1'h0}}, c.uart0_ext_baud} : {UART_N{1'h1}};
    g.adc_hold = stopped;
    g.dac_hold = stopped;
    g.rto_hold = stopped;
    g.key_run = 1'h1;
    g.port_hold = stopped;
    g.cpu_regs_hold = stopped;
    g.ram_retain = stopped;
    return g;
  endfunction

  // sequencer next values
  always_comb begin
    next_state = state;
    next_count = count;
    next_stab_sel = stab_sel;
    next_resume = 1'h0;
    unique case (state)
      S_RUN: begin
        if (idle_req && !irq_pending) begin
          next_state = S_IDLE;
        end
      end
      S_IDLE: begin
        if (release_evt) begin
          next_state = S_SETUP;
          next_count = CNT_ZERO;
          next_stab_sel = osc_stabilise_select;
        end
      end
      S_SETUP: begin
        if (count == target) begin
          next_state = S_RUN;
          next_resume = 1'h1;
        end else begin
          next_count = count + CNT_ONE;
        end
      end
    endcase
    next_gates = gates_for(next_state, cfg);
    next_in_idle = (next_state == S_IDLE);
    next_in_setup = (next_state == S_SETUP);
  end

  // sequencer registers; reset acts as a normal reset, straight to running
  always_ff @(posedge clk) begin
    if (reset) begin
      state <= S_RUN;
      count <= CNT_ZERO;
      stab_sel <= SEL_RESET;
      gates <= gates_for(S_RUN, '0);
      in_idle <= 1'h0;
      in_setup <= 1'h0;
      resume <= 1'h0;
    end else begin
      state <= next_state;
      count <= next_count;
      stab_sel <= next_stab_sel;
      gates <= next_gates;
      in_idle <= next_in_idle;
      in_setup <= next_in_setup;
      resume <= next_resume;
    end
  end

  property p_pending_refuses;
    @(posedge clk) disable iff (reset)
      (state == S_RUN && idle_req && irq_pending) |=> !in_idle && gates.cpu_run;
  endproperty
  a_pending_refuses: assert property (p_pending_refuses) else $error("idle entered with interrupt pending");

  property p_core_halted;
    @(posedge clk) disable iff (reset)
      in_idle |-> !gates.cpu_run && !gates.pll_run && !gates.dma_run && !gates.i2c_run
        && !gates.crc_run && !gates.timer_p_run && gates.main_osc_run;
  endproperty
  a_core_halted: assert property (p_core_halted) else $error("core block runs in idle");

  property p_irq_detect;
    @(posedge clk) disable iff (reset)
      in_idle |-> !gates.irq_service_run && gates.irq_detect_run;
  endproperty
  a_irq_detect: assert property (p_irq_detect) else $error("interrupt gating wrong in idle");

  property p_timer_m_slow;
    @(posedge clk) disable iff (reset)
      (state == S_IDLE && next_state == S_IDLE && !cfg.timer_m_intosc8 && !cfg.subclock_used)
        |=> !gates.timer_m_run;
  endproperty
  a_timer_m_slow: assert property (p_timer_m_slow) else $error("timer M runs on fast clock in idle");

  property p_wdt_slow;
    @(posedge clk) disable iff (reset)
      (state == S_IDLE && next_state == S_IDLE && !cfg.wdt_intosc8 && !cfg.subclock_used) |=> !gates.wdt_run;
  endproperty
  a_wdt_slow: assert property (p_wdt_slow) else $error("watchdog runs on fast clock in idle");

  property p_watch_src;
    @(posedge clk) disable iff (reset)
      (state == S_IDLE && next_state == S_IDLE && (cfg.watch_brg || cfg.subclock_used)) |=> gates.watch_run;
  endproperty
  a_watch_src: assert property (p_watch_src) else $error("watch timer stopped in idle");

  property p_csi_ext;
    @(posedge clk) disable iff (reset)
      (state == S_IDLE && next_state == S_IDLE) |=> gates.csi_run == $past(cfg.csi_ext_clock);
  endproperty
  a_csi_ext: assert property (p_csi_ext) else $error("serial channel gating wrong in idle");

  property p_uart_halt;
    @(posedge clk) disable iff (reset)
      in_idle |-> gates.uart_run[UART_N-1:1] == '0;
  endproperty
  a_uart_halt: assert property (p_uart_halt) else $error("async channel runs in idle");

  property p_holds;
    @(posedge clk) disable iff (reset)
      in_idle |-> gates.port_hold && gates.cpu_regs_hold && gates.ram_retain && gates.key_run
        && gates.adc_hold && gates.dac_hold && gates.rto_hold;
  endproperty
  a_holds: assert property (p_holds) else $error("hold missing in idle");

  sequence s_release;
    in_idle && release_evt;
  endsequence
  sequence s_setup_start;
    in_setup && count == CNT_ZERO && !gates.cpu_run;
  endsequence
  property p_release_setup;
    @(posedge clk) disable iff (reset)
      s_release |=> s_setup_start;
  endproperty
  a_release_setup: assert property (p_release_setup) else $error("release did not start setup");

  property p_setup_holds;
    @(posedge clk) disable iff (reset)
      (in_setup && count != target) |=> in_setup && count == $past(count) + CNT_ONE;
  endproperty
  a_setup_holds: assert property (p_setup_holds) else $error("setup wait cut short");

  property p_setup_core;
    @(posedge clk) disable iff (reset)
      in_setup |-> !gates.cpu_run && gates.pll_run && gates.main_osc_run && !resume;
  endproperty
  a_setup_core: assert property (p_setup_core) else $error("core released during setup wait");

  property p_resume_on_overflow;
    @(posedge clk) disable iff (reset)
      resume |-> $past(in_setup) && $past(count) == $past(target) && gates.cpu_run && !in_idle;
  endproperty
  a_resume_on_overflow: assert property (p_resume_on_overflow) else $error("resumed before setup done");

endmodule

// ---- test/testbench.sv ----
// self-checking bench for the deep idle standby controller
`timescale 1ns/100ps
module testbench;
  import standby_pkg::*;
  // short setup base keeps the release waits brief
  localparam int BASE = 2;
  logic clk = 1'h0;
  logic reset = 1'h1;
  logic idle_req = 1'h0;
  logic irq_pending = 1'h0;
  logic release_evt = 1'h0;
  logic [SEL_W-1:0] sel = 3'h0;
  clock_select_t cfg = '0;
  clock_select_t c;
  gate_t gates;
  logic in_idle;
  logic in_setup;
  logic resume;
  integer seed = 32'h36f444cd;
  int errors = 0;
  int cmp_count = 0;
  int n;
  logic [31:0] r;

  deep_idle_state #(.STAB_BASE(BASE)) DUT (.clk(clk), .reset(reset), .idle_req(idle_req),
    .irq_pending(irq_pending), .release_evt(release_evt), .osc_stabilise_select(sel),
    .cfg(cfg), .gates(gates), .in_idle(in_idle), .in_setup(in_setup), .resume(resume));

  always #20 clk = ~clk;

  // one compare point, reports and counts
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic results();
    $display("compares %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // idle pattern worked out from the clock source choices
  function automatic gate_t idle_gates(clock_select_t s);
    gate_t g;
    g = '0;
    g.main_osc_run = 1'h1;
    g.irq_detect_run = 1'h1;
    g.timer_m_run = s.timer_m_intosc8 | (s.timer_m_sub & s.subclock_used);
    g.wdt_run = s.wdt_intosc8 | (s.wdt_sub & s.subclock_used);
    g.watch_run = s.watch_brg | s.subclock_used;
    g.csi_run = s.csi_ext_clock;
    g.uart_run[0] = s.uart0_ext_baud;
    g.key_run = 1'h1;
    {g.adc_hold, g.dac_hold, g.rto_hold, g.port_hold, g.cpu_regs_hold, g.ram_retain} = 6'h3F;
    return g;
  endfunction

  // retention flag left out of run compares, its running level is open
  function automatic gate_t run_view(gate_t g);
    g.ram_retain = 1'h0;
    return g;
  endfunction

  function automatic gate_t run_gates();
    gate_t g;
    g = '1;
    {g.adc_hold, g.dac_hold, g.rto_hold, g.port_hold, g.cpu_regs_hold, g.ram_retain} = 6'h00;
    return g;
  endfunction

  initial begin
    repeat (20) @(posedge clk);
    reset <= 1'h0;
    #1;
    check(run_view(gates), run_gates());
    check(in_idle, 1'h0);
    // pending interrupt blocks entry, stray release ignored
    @(posedge clk);
    irq_pending <= 1'h1;
    idle_req <= 1'h1;
    release_evt <= 1'h1;
    @(posedge clk);
    irq_pending <= 1'h0;
    idle_req <= 1'h0;
    release_evt <= 1'h0;
    #1;
    check(in_idle, 1'h0);
    check(in_setup, 1'h0);
    $display("test refuse done");
    for (int i = 0; i < 10; i++) begin
      r = $random(seed);
      c = (i == 0) ? '0 : (i == 1) ? '1 : r[$bits(clock_select_t)-1:0];
      @(posedge clk);
      cfg <= c;
      // converters taken as stopped by software before entry
      idle_req <= 1'h1;
      @(posedge clk);
      idle_req <= 1'h0;
      #1;
      check(in_idle, 1'h1);
      check(gates, idle_gates(c));
      // sources change mid-idle, gating tracks them
      r = $random(seed);
      c = r[$bits(clock_select_t)-1:0];
      @(posedge clk);
      cfg <= c;
      repeat (2) @(posedge clk);
      #1;
      check(in_idle, 1'h1);
      check(gates, idle_gates(c));
      @(posedge clk);
      release_evt <= 1'h1;
      sel <= SEL_W'(i % 8);
      @(posedge clk);
      release_evt <= 1'h0;
      #1;
      check(in_idle, 1'h0);
      check(gates, idle_gates(c) | 32'h40000000);
      n = 0;
      while (resume !== 1'h1 && n < 1000) begin
        check(in_setup, 1'h1);
        @(posedge clk);
        #1;
        n++;
      end
      // timeout counts as a mismatch and goes to the report
      if (n >= 1000) begin
        errors++;
        break;
      end
      // wait length set by the captured select
      check(n, 2 ** (BASE + i % 8));
      check(in_setup, 1'h0);
      check(run_view(gates), run_gates());
      @(posedge clk);
      #1;
      check(resume, 1'h0);
      $display("test %0d done", i);
    end
    // reset in the middle of a setup wait drops straight back to running
    @(posedge clk);
    idle_req <= 1'h1;
    @(posedge clk);
    idle_req <= 1'h0;
    release_evt <= 1'h1;
    @(posedge clk);
    release_evt <= 1'h0;
    reset <= 1'h1;
    @(posedge clk);
    reset <= 1'h0;
    #1;
    check(in_setup, 1'h0);
    check(run_view(gates), run_gates());
    check(resume, 1'h0);
    $display("test reset in setup done");
    results();
  end
endmodule
